// [verilog/ues_pkg.sv]
// Shared constants and carrier types for the enhanced status and control registers
package ues_pkg;
   localparam int          DW             = 8;
   localparam int          AW             = 3;
   localparam logic [2:0]  A_THR_DLL      = 3'h0;
   localparam logic [2:0]  A_DLM          = 3'h1;
   localparam logic [2:0]  A_ISR_DLD      = 3'h2;
   localparam logic [2:0]  A_SFR          = 3'h4;
   localparam logic [2:0]  A_GPIO_MASK    = 3'h4;
   localparam logic [2:0]  A_GPIO_TRI     = 3'h5;
   localparam logic [2:0]  A_MSR          = 3'h6;
   localparam logic [2:0]  A_GPIO_POL     = 3'h6;
   localparam logic [2:0]  A_SPR          = 3'h7;
   localparam logic [2:0]  A_GPIO_DIR     = 3'h7;
   localparam logic [7:0]  LCR_ENH_KEY    = 8'hBF;
   localparam int          LCR_DLAB       = 7;
   localparam logic [2:0]  LCR_PAR_FORCE0 = 3'h7;
   localparam int          MCR_DTR        = 0;
   localparam int          MCR_RTS        = 1;
   localparam int          MCR_OUT1       = 2;
   localparam int          MCR_OUT2       = 3;
   localparam int          MCR_LOOP       = 4;
   localparam int          IER_MODEM      = 3;
   localparam int          EFR_UNLOCK     = 4;
   localparam int          EFR_AUTO_CTS   = 7;
   localparam int          FEATURE_CONTROL_RS485     = 3;
   localparam int          FEATURE_CONTROL_SWAP      = 6;
   localparam int          SFR_GPIO_EN    = 0;
   localparam int          SFR_BANK       = 1;
   localparam int          SFR_GPIO_IRQ   = 2;
   localparam int          SFR_FAST_IR    = 3;
   localparam int          SFR_TX_DIS     = 4;
   localparam int          SFR_RX_DIS     = 5;
   localparam int          SFR_NINE_BIT   = 6;
   localparam int          SFR_TX_ADDR    = 7;
   localparam logic [7:0]  SFR_FREE_MASK  = 8'h07;
   localparam int          ENHANCED_MODE_SELECT_ALT       = 0;
   localparam int          ENHANCED_MODE_SELECT_TXCNT     = 1;
   localparam int          ENHANCED_MODE_SELECT_IMM       = 2;
   localparam int          ENHANCED_MODE_SELECT_RTS_INV   = 3;
   localparam int          ENHANCED_MODE_SELECT_TRI       = 4;
   localparam int          ENHANCED_MODE_SELECT_LSR_IMM   = 6;
   localparam int          ENHANCED_MODE_SELECT_CLR_RD    = 7;
   localparam logic [7:0]  ENHANCED_MODE_SELECT_WR_MASK   = 8'hDF;
   localparam logic [7:0]  SPR_RST        = 8'hFF;
   localparam logic [7:0]  ZERO8          = 8'h00;
   localparam logic [1:0]  BRG_BOTH       = 2'h0;
   localparam logic [1:0]  BRG_TX         = 2'h1;
   localparam logic [1:0]  BRG_NONE       = 2'h2;
   localparam logic [1:0]  BRG_RX         = 2'h3;

   typedef struct packed {
      logic [15:0] whole;
      logic [3:0]  frac;
      logic [1:0]  samp;
   } ues_brg_s;

   typedef struct packed {
      logic tx_disable;
      logic rx_disable;
      logic nine_bit;
      logic fast_ir;
      logic tx_halt;
      logic tx_immediate;
   } ues_mode_s;
endpackage

// [verilog/ues_regs.sv]
// Enhanced status, special function, scratch, GPIO, mode select and divisor registers
`timescale 1ns/10ps
module ues_regs
   import ues_pkg::*;
#(
   parameter int GPIO_W = 16
) (
   input  wire logic              SYS_CLK_I,
   input  wire logic              RST_N_I,
   input  wire logic [AW-1:0]     ADDR_I,
   input  wire logic              CS_N_I,
   input  wire logic              RD_N_I,
   input  wire logic              WR_N_I,
   input  wire logic [DW-1:0]     DATA_I,
   output logic      [DW-1:0]     DATA_O,
   output logic                   DATA_OE_N_O,
   input  wire logic [7:0]        LINE_CTRL_I,
   input  wire logic [7:0]        MODEM_CTRL_I,
   input  wire logic [7:0]        IRQ_ENABLE_I,
   input  wire logic [7:0]        FEATURE_UNLOCK_I,
   input  wire logic [7:0]        FEATURE_CONTROL_I,
   input  wire logic              FIFO_EN_I,
   input  wire logic [7:0]        RX_LEVEL_I,
   input  wire logic [7:0]        TX_LEVEL_I,
   input  wire logic              TX_SENT_I,
   input  wire logic              TX_ACTIVE_I,
   input  wire logic              SER_TX_I,
   input  wire logic              ERR_IN_FIFO_I,
   input  wire logic              ERR_AT_HOLD_I,
   input  wire logic              PAUSE_EVT_I,
   input  wire logic              RESUME_EVT_I,
   input  wire logic              SPECIAL_EVT_I,
   input  wire logic              RX_CHAR_EVT_I,
   input  wire logic              CTS_N_I,
   input  wire logic              DSR_N_I,
   input  wire logic              RI_N_I,
   input  wire logic              CD_N_I,
   output logic                   TX_O,
   output logic                   TX_OE_N_O,
   output logic                   RTS_N_O,
   output logic                   RTS_OE_N_O,
   output logic                   DTR_N_O,
   output logic                   DTR_OE_N_O,
   input  wire logic [GPIO_W-1:0] GPIO_I,
   output logic      [GPIO_W-1:0] GPIO_O,
   output logic      [GPIO_W-1:0] GPIO_OE_N_O,
   output logic                   MODEM_IRQ_O,
   output logic                   GPIO_IRQ_O,
   output logic                   LINE_ERR_IRQ_O,
   output logic                   PAUSE_IRQ_O,
   output logic                   SPECIAL_IRQ_O,
   output logic                   TX_NINTH_O,
   output ues_mode_s              MODE_O,
   output ues_brg_s               TX_BRG_O,
   output ues_brg_s               RX_BRG_O
);
   localparam int BANK_W = GPIO_W / 2;

   logic                rd_q_r, wr_q_r;
   logic                rd_go, wr_go;
   logic                enh, dlab, unlock, swap, loopback;
   logic [7:0]          sfr_r, enhanced_mode_select_r, spr_r;
   logic [7:0]          sfr_nxt;
   logic [3:0]          stat, stat_prev_r, delta_r;
   logic [GPIO_W-1:0]   g_lvl_r, g_mask_r, g_tri_r, g_pol_r, g_dir_r;
   logic [BANK_W-1:0]   bank_lvl;
   logic                bank;
   logic                alt_ph_r, imm_pend_r;
   logic [1:0]          div_sel_r, div_sel_w;
   ues_brg_s            tx_brg_r, rx_brg_r, rd_brg;
   logic [7:0]          rd_mux;
   logic                thr_wr, isr_rd, msr_rd, gsel;

   assign rd_go    = !CS_N_I && !RD_N_I && !rd_q_r;
   assign wr_go    = !CS_N_I && !WR_N_I && !wr_q_r;
   assign enh      = (LINE_CTRL_I == LCR_ENH_KEY);
   assign dlab     = LINE_CTRL_I[LCR_DLAB] && !enh;
   assign unlock   = FEATURE_UNLOCK_I[EFR_UNLOCK];
   assign swap     = FEATURE_CONTROL_I[FEATURE_CONTROL_SWAP];
   assign loopback = MODEM_CTRL_I[MCR_LOOP];
   assign gsel     = sfr_r[SFR_GPIO_EN];
   assign bank     = sfr_r[SFR_BANK];
   assign thr_wr   = wr_go && !LINE_CTRL_I[LCR_DLAB] && ADDR_I == A_THR_DLL;
   assign isr_rd   = rd_go && !LINE_CTRL_I[LCR_DLAB] && ADDR_I == A_ISR_DLD;
   assign msr_rd   = rd_go && !enh && ADDR_I == A_MSR;

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         rd_q_r <= 1'b0;
         wr_q_r <= 1'b0;
      end else begin
         rd_q_r <= !CS_N_I && !RD_N_I;
         wr_q_r <= !CS_N_I && !WR_N_I;
      end
   end

   // Modem status: bit 0 clear-to-send, 1 set-ready, 2 ring, 3 carrier
   assign stat = loopback ? {MODEM_CTRL_I[MCR_OUT2], MODEM_CTRL_I[MCR_OUT1],
                             MODEM_CTRL_I[MCR_DTR], MODEM_CTRL_I[MCR_RTS]}
                          : ~{CD_N_I, RI_N_I, DSR_N_I, CTS_N_I};

   // A change in the read cycle sets the flag again, so no event is lost
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         stat_prev_r <= 4'h0;
         delta_r     <= 4'h0;
      end else begin
         stat_prev_r <= stat;
         delta_r[0]  <= (stat[0] != stat_prev_r[0]) || (delta_r[0] && !msr_rd);
         delta_r[1]  <= (stat[1] != stat_prev_r[1]) || (delta_r[1] && !msr_rd);
         delta_r[2]  <= (!stat[2] && stat_prev_r[2]) || (delta_r[2] && !msr_rd);
         delta_r[3]  <= (stat[3] != stat_prev_r[3]) || (delta_r[3] && !msr_rd);
      end
   end
   assign MODEM_IRQ_O = IRQ_ENABLE_I[IER_MODEM] && |delta_r;

   // Special function register: low three bits always, others only unlocked, except bit 7, which any THR write clears
   always_comb begin
      sfr_nxt = sfr_r;
      if (thr_wr) begin
         sfr_nxt[SFR_TX_ADDR] = 1'b0;
      end
      if (wr_go && dlab && ADDR_I == A_SFR) begin
         if (unlock) begin
            sfr_nxt = DATA_I;
         end else begin
            sfr_nxt = (sfr_r & ~SFR_FREE_MASK) | (DATA_I & SFR_FREE_MASK);
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         sfr_r      <= ZERO8;
         TX_NINTH_O <= 1'b0;
      end else begin
         sfr_r <= sfr_nxt;
         if (thr_wr) begin
            TX_NINTH_O <= sfr_r[SFR_TX_ADDR]
                          && LINE_CTRL_I[5:3] == LCR_PAR_FORCE0;
         end
      end
   end

   // Scratch has no sleep term: only reset reloads it
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         spr_r <= SPR_RST;
      end else if (wr_go && !enh && ADDR_I == A_SPR && !gsel && !swap) begin
         spr_r <= DATA_I;
      end
   end

   // Mode select and the alternating level counter phase
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         enhanced_mode_select_r     <= ZERO8;
         alt_ph_r   <= 1'b0;
         imm_pend_r <= 1'b0;
      end else begin
         if (wr_go && !enh && ADDR_I == A_SPR && !gsel && swap) begin
            enhanced_mode_select_r   <= DATA_I & ENHANCED_MODE_SELECT_WR_MASK;
            alt_ph_r <= 1'b0;
         end else begin
            if (rd_go && !enh && ADDR_I == A_SPR && !gsel && swap
                && enhanced_mode_select_r[ENHANCED_MODE_SELECT_ALT] && enhanced_mode_select_r[ENHANCED_MODE_SELECT_TXCNT]) begin
               alt_ph_r <= !alt_ph_r;
            end
            if (TX_SENT_I && imm_pend_r) begin
               enhanced_mode_select_r[ENHANCED_MODE_SELECT_IMM] <= 1'b0;
            end
         end
         if (TX_SENT_I) begin
            imm_pend_r <= 1'b0;
         end else if (thr_wr && MODE_O.tx_immediate) begin
            imm_pend_r <= 1'b1;
         end
      end
   end

   // GPIO registers act on the selected half of the pins
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         g_lvl_r  <= '0;
         g_mask_r <= '0;
         g_tri_r  <= '0;
         g_pol_r  <= '0;
         g_dir_r  <= '0;
      end else if (wr_go && gsel) begin
         if (!enh && ADDR_I == A_SPR) begin
            for (int i = 0; i < BANK_W; i++) begin
               if (!g_dir_r[i + BANK_W * bank]) begin
                  g_lvl_r[i + BANK_W * bank] <= DATA_I[i];
               end
            end
         end else if (enh) begin
            unique case (ADDR_I)
               A_GPIO_MASK: g_mask_r[BANK_W * bank +: BANK_W] <= DATA_I[BANK_W-1:0];
               A_GPIO_TRI:  g_tri_r[BANK_W * bank +: BANK_W]  <= DATA_I[BANK_W-1:0];
               A_GPIO_POL:  g_pol_r[BANK_W * bank +: BANK_W]  <= DATA_I[BANK_W-1:0];
               A_GPIO_DIR:  g_dir_r[BANK_W * bank +: BANK_W]  <= DATA_I[BANK_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Direction 1 is input; three-state set floats an output
   assign GPIO_O      = g_lvl_r;
   assign GPIO_OE_N_O = g_dir_r | g_tri_r;
   assign GPIO_IRQ_O  = sfr_r[SFR_GPIO_IRQ]
                        && |(g_dir_r & g_mask_r & (GPIO_I ^ g_pol_r));
   always_comb begin
      for (int i = 0; i < BANK_W; i++) begin
         bank_lvl[i] = g_dir_r[i + BANK_W * bank] ? GPIO_I[i + BANK_W * bank]
                                                  : g_lvl_r[i + BANK_W * bank];
      end
   end

   // Divisor sets; the top fraction bits pick which set a write reaches
   assign div_sel_w = (wr_go && dlab && unlock && ADDR_I == A_ISR_DLD) ? DATA_I[7:6]
                                                                      : div_sel_r;

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         div_sel_r <= BRG_BOTH;
         tx_brg_r  <= '0;
         rx_brg_r  <= '0;
      end else begin
         div_sel_r <= div_sel_w;
         if (wr_go && dlab && div_sel_w != BRG_NONE) begin
            unique case (ADDR_I)
               A_THR_DLL: begin
                  if (div_sel_w != BRG_RX) tx_brg_r.whole[7:0] <= DATA_I;
                  if (div_sel_w != BRG_TX) rx_brg_r.whole[7:0] <= DATA_I;
               end
               A_DLM: begin
                  if (div_sel_w != BRG_RX) tx_brg_r.whole[15:8] <= DATA_I;
                  if (div_sel_w != BRG_TX) rx_brg_r.whole[15:8] <= DATA_I;
               end
               A_ISR_DLD: begin
                  // Fraction and sampling fields only while unlocked
                  if (unlock && div_sel_w != BRG_RX) {tx_brg_r.samp, tx_brg_r.frac} <= DATA_I[5:0];
                  if (unlock && div_sel_w != BRG_TX) {rx_brg_r.samp, rx_brg_r.frac} <= DATA_I[5:0];
               end
               default: ;
            endcase
         end
      end
   end
   assign TX_BRG_O = tx_brg_r;
   assign RX_BRG_O = rx_brg_r;
   assign rd_brg   = (div_sel_r == BRG_RX) ? rx_brg_r : tx_brg_r;

   // Read data; write-only registers read as zero, except mode select, whose address reads a level count
   always_comb begin
      rd_mux = ZERO8;
      if (dlab && ADDR_I == A_THR_DLL) begin
         rd_mux = rd_brg.whole[7:0];
      end else if (dlab && ADDR_I == A_DLM) begin
         rd_mux = rd_brg.whole[15:8];
      end else if (dlab && unlock && ADDR_I == A_ISR_DLD) begin
         rd_mux = {div_sel_r, rd_brg.samp, rd_brg.frac};
      end else if (!enh && ADDR_I == A_MSR) begin
         rd_mux = {stat, delta_r};
      end else if (!enh && ADDR_I == A_SPR) begin
         if (gsel) begin
            rd_mux = 8'(bank_lvl);
         end else if (swap) begin
            // Bit 0 clear: receive; bit 0 alone: transmit; both: alternate
            rd_mux = (enhanced_mode_select_r[ENHANCED_MODE_SELECT_ALT] && (!enhanced_mode_select_r[ENHANCED_MODE_SELECT_TXCNT] || alt_ph_r))
                     ? TX_LEVEL_I : RX_LEVEL_I;
         end else begin
            rd_mux = spr_r;
         end
      end else if (enh && gsel) begin
         unique case (ADDR_I)
            A_GPIO_MASK: rd_mux = 8'(g_mask_r[BANK_W * bank +: BANK_W]);
            A_GPIO_TRI:  rd_mux = 8'(g_tri_r[BANK_W * bank +: BANK_W]);
            A_GPIO_POL:  rd_mux = 8'(g_pol_r[BANK_W * bank +: BANK_W]);
            A_GPIO_DIR:  rd_mux = 8'(g_dir_r[BANK_W * bank +: BANK_W]);
            default:     rd_mux = ZERO8;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         DATA_O <= ZERO8;
      end else if (rd_go) begin
         DATA_O <= rd_mux;
      end
   end
   assign DATA_OE_N_O = !(rd_q_r && !CS_N_I && !RD_N_I);

   // Interrupt flags shared with the rest of the UART
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         PAUSE_IRQ_O   <= 1'b0;
         SPECIAL_IRQ_O <= 1'b0;
      end else begin
         PAUSE_IRQ_O   <= PAUSE_EVT_I || (PAUSE_IRQ_O && !isr_rd
                          && !(RESUME_EVT_I && !enhanced_mode_select_r[ENHANCED_MODE_SELECT_CLR_RD]));
         SPECIAL_IRQ_O <= SPECIAL_EVT_I || (SPECIAL_IRQ_O && !isr_rd
                          && !(RX_CHAR_EVT_I && !enhanced_mode_select_r[ENHANCED_MODE_SELECT_CLR_RD]));
      end
   end
   assign LINE_ERR_IRQ_O = enhanced_mode_select_r[ENHANCED_MODE_SELECT_LSR_IMM] ? ERR_IN_FIFO_I : ERR_AT_HOLD_I;

   // Pin drivers
   always_ff @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         TX_O    <= 1'b1;
         RTS_N_O <= 1'b1;
         DTR_N_O <= 1'b1;
      end else begin
         TX_O    <= SER_TX_I;
         DTR_N_O <= !MODEM_CTRL_I[MCR_DTR];
         if (FEATURE_CONTROL_I[FEATURE_CONTROL_RS485]) begin
            RTS_N_O <= !TX_ACTIVE_I ^ enhanced_mode_select_r[ENHANCED_MODE_SELECT_RTS_INV];
         end else begin
            RTS_N_O <= !MODEM_CTRL_I[MCR_RTS];
         end
      end
   end
   assign TX_OE_N_O  = enhanced_mode_select_r[ENHANCED_MODE_SELECT_TRI];
   assign RTS_OE_N_O = enhanced_mode_select_r[ENHANCED_MODE_SELECT_TRI];
   assign DTR_OE_N_O = enhanced_mode_select_r[ENHANCED_MODE_SELECT_TRI];

   assign MODE_O.tx_disable   = sfr_r[SFR_TX_DIS];
   assign MODE_O.rx_disable   = sfr_r[SFR_RX_DIS];
   assign MODE_O.nine_bit     = sfr_r[SFR_NINE_BIT];
   assign MODE_O.fast_ir      = sfr_r[SFR_FAST_IR];
   assign MODE_O.tx_halt      = FEATURE_UNLOCK_I[EFR_AUTO_CTS] && CTS_N_I;
   assign MODE_O.tx_immediate = FIFO_EN_I && enhanced_mode_select_r[ENHANCED_MODE_SELECT_IMM];

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_msr_read;
      msr_rd && stat == stat_prev_r;
   endsequence

   a_ri_delta_rise:   assert property (!loopback && $rose(RI_N_I) |=> delta_r[2])
      else $error("ring delta missed on rising pin");
   a_ri_delta_fall:   assert property (!loopback && $fell(RI_N_I) && !delta_r[2]
                         |=> !delta_r[2])
      else $error("ring delta set on falling pin");
   a_cts_status:      assert property (rd_go && !enh && ADDR_I == A_MSR
                         |=> DATA_O[4] == $past(loopback ? MODEM_CTRL_I[MCR_RTS] : !CTS_N_I))
      else $error("clear-to-send status wrong");
   a_msr_read_clear:  assert property (s_msr_read |=> delta_r == 4'h0 && !MODEM_IRQ_O)
      else $error("modem deltas not cleared by read");
   a_addr_bit_clear:  assert property (thr_wr && !(wr_go && dlab) |=> !sfr_r[SFR_TX_ADDR])
      else $error("address bit did not self-clear");
   a_ninth_bit:       assert property (thr_wr && sfr_r[SFR_TX_ADDR]
                         && LINE_CTRL_I[5:3] == LCR_PAR_FORCE0 |=> TX_NINTH_O)
      else $error("ninth bit not set");
   a_locked_sfr:      assert property (wr_go && dlab && ADDR_I == A_SFR && !unlock
                         && !thr_wr |=> $stable(sfr_r[7:3]))
      else $error("locked special bits changed");
   a_alt_first_rx:    assert property (wr_go && !enh && ADDR_I == A_SPR && !gsel && swap
                         |=> !alt_ph_r)
      else $error("alternating phase not reset");
   a_rts_rs485:       assert property (FEATURE_CONTROL_I[FEATURE_CONTROL_RS485] && TX_ACTIVE_I
                         && !enhanced_mode_select_r[ENHANCED_MODE_SELECT_RTS_INV] |=> !RTS_N_O)
      else $error("rs485 direction wrong");
   a_tri_modem:       assert property (enhanced_mode_select_r[ENHANCED_MODE_SELECT_TRI] |-> TX_OE_N_O && RTS_OE_N_O
                         && DTR_OE_N_O)
      else $error("modem outputs driven while floated");
endmodule // ues_regs

// [testbench/ues_host.sv]
// Host processor model driving the parallel register port
`timescale 1ns/10ps
module ues_host
   import ues_pkg::*;
(
   input  wire logic          clk_i,
   input  wire logic [DW-1:0] dout_i,
   input  wire logic          oe_n_i,
   output logic      [AW-1:0] addr_o,
   output logic               cs_n_o,
   output logic               rd_n_o,
   output logic               wr_n_o,
   output logic      [DW-1:0] din_o
);
   initial begin
      addr_o = '0;
      din_o = 8'hFF;
      {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
   end
   // Released data bus shows the inverse so a stale value never passes
   task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_i);
      addr_o <= a;
      din_o <= d;
      {cs_n_o, wr_n_o} <= 2'h0;
      repeat (2) @(posedge clk_i);
      {cs_n_o, wr_n_o} <= 2'h3;
      din_o <= ~d;
   endtask
   task rd(input logic [AW-1:0] a, output logic [DW-1:0] d, output logic oe);
      @(posedge clk_i);
      addr_o <= a;
      {cs_n_o, rd_n_o} <= 2'h0;
      repeat (2) @(posedge clk_i);
      d = dout_i;
      oe = oe_n_i;
      {cs_n_o, rd_n_o} <= 2'h3;
   endtask
endmodule // ues_host

// [testbench/test_ues_regs.sv]
// Self-checking bench for the enhanced status and control registers
`timescale 1ns/10ps
module test_ues_regs;
   import ues_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, oe_n, cs_n, rd_n, wr_n, irq, t_oe, ninth, oe;
   logic [7:0] line_control = '0, modem_control = '0, irq_enable = 8'h08, feature_unlock = '0, feature_control = '0, dout, din, d;
   logic [7:0] rxl = 8'h11, txl = 8'h22;
   logic [10:0] misc = '0;
   logic [3:0] mdm_n = 4'hF;
   logic [15:0] gpi = '0, gpo, gpoe;
   logic [2:0] addr;
   logic rts, girq, lerr, pirq;
   ues_mode_s mode;
   ues_brg_s txb, rxb;
   int n_fail = 0, checks_done = 0;
   initial forever #20 clk = ~clk;
   ues_host host (.clk_i(clk), .dout_i(dout), .oe_n_i(oe_n), .addr_o(addr), .cs_n_o(cs_n),
      .rd_n_o(rd_n), .wr_n_o(wr_n), .din_o(din));
   ues_regs dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .CS_N_I(cs_n), .RD_N_I(rd_n),
      .WR_N_I(wr_n), .DATA_I(din), .DATA_O(dout), .DATA_OE_N_O(oe_n), .LINE_CTRL_I(line_control),
      .MODEM_CTRL_I(modem_control), .IRQ_ENABLE_I(irq_enable), .FEATURE_UNLOCK_I(feature_unlock), .FEATURE_CONTROL_I(feature_control),
      .FIFO_EN_I(misc[0]), .RX_LEVEL_I(rxl), .TX_LEVEL_I(txl), .TX_SENT_I(misc[1]),
      .TX_ACTIVE_I(misc[2]), .SER_TX_I(misc[3]), .ERR_IN_FIFO_I(misc[4]),
      .ERR_AT_HOLD_I(misc[5]), .PAUSE_EVT_I(misc[6]), .RESUME_EVT_I(misc[7]),
      .SPECIAL_EVT_I(misc[8]), .RX_CHAR_EVT_I(misc[9]), .CTS_N_I(mdm_n[0]),
      .DSR_N_I(mdm_n[1]), .RI_N_I(mdm_n[2]), .CD_N_I(mdm_n[3]), .TX_O(), .TX_OE_N_O(t_oe),
      .RTS_N_O(rts), .RTS_OE_N_O(), .DTR_N_O(), .DTR_OE_N_O(), .GPIO_I(gpi), .GPIO_O(gpo),
      .GPIO_OE_N_O(gpoe), .MODEM_IRQ_O(irq), .GPIO_IRQ_O(girq), .LINE_ERR_IRQ_O(lerr),
      .PAUSE_IRQ_O(pirq), .SPECIAL_IRQ_O(), .TX_NINTH_O(ninth), .MODE_O(mode), .TX_BRG_O(txb),
      .RX_BRG_O(rxb));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] e, input string n);
      host.rd(a, d, oe);
      chk(n, d, e);
      chk("read_oe_n", oe, 1'b0);
   endtask
   task automatic pins(input logic [3:0] v);
      mdm_n <= v;
      repeat (3) @(posedge clk);
   endtask
   task conclude();
      $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("mode", mode, 6'h00);
      rc(A_SPR, 8'hFF, "scratch");
      host.wr(A_SPR, 8'h5A);
      rc(A_SPR, 8'h5A, "scratch");
      $display("test reset done");
      pins(4'hA);
      chk("modem_irq", irq, 1'b1);
      rc(A_MSR, 8'h51, "modem_status");
      @(posedge clk);
      chk("modem_irq", irq, 1'b0);
      pins(4'hE);
      rc(A_MSR, 8'h14, "modem_status");
      rc(A_MSR, 8'h10, "modem_status");
      pins(4'h6);
      rc(A_MSR, 8'h98, "modem_status");
      modem_control <= 8'h1F;
      host.rd(A_MSR, d, oe);
      chk("loop_status", d & 8'hF0, 8'hF0);
      modem_control <= 8'h12;
      host.rd(A_MSR, d, oe);
      chk("loop_status", d & 8'hF0, 8'h10);
      modem_control <= 8'h00;
      $display("test modem done");
      line_control <= 8'h80;
      host.wr(A_THR_DLL, 8'h34);
      host.wr(A_DLM, 8'h12);
      chk("tx_whole", txb.whole, 16'h1234);
      chk("rx_whole", rxb.whole, 16'h1234);
      host.wr(A_ISR_DLD, 8'h05);
      chk("tx_frac", txb.frac, 4'h0);
      feature_unlock <= 8'h10;
      host.wr(A_ISR_DLD, 8'h47);
      host.wr(A_THR_DLL, 8'h56);
      chk("tx_whole", txb.whole, 16'h1256);
      chk("tx_frac", txb.frac, 4'h7);
      chk("rx_whole", rxb.whole, 16'h1234);
      $display("test divisor done");
      feature_unlock <= 8'h00;
      host.wr(A_SFR, 8'h70);
      chk("tx_disable", mode.tx_disable, 1'b0);
      feature_unlock <= 8'h10;
      host.wr(A_SFR, 8'h70);
      chk("dis_nine", {mode.tx_disable, mode.rx_disable, mode.nine_bit}, 3'h7);
      host.wr(A_SFR, 8'h80);
      line_control <= 8'h38;
      host.wr(A_THR_DLL, 8'h55);
      chk("ninth", ninth, 1'b1);
      host.wr(A_THR_DLL, 8'h55);
      chk("ninth", ninth, 1'b0);
      $display("test special done");
      line_control <= 8'h80;
      host.wr(A_SFR, 8'h01);
      line_control <= LCR_ENH_KEY;
      host.wr(A_GPIO_DIR, 8'h0F);
      line_control <= 8'h00;
      gpi <= 16'h0006;
      host.wr(A_SPR, 8'hA5);
      chk("gpio_oe_n", gpoe, 16'h000F);
      chk("gpio_out", gpo[7:4], 4'hA);
      rc(A_SPR, 8'hA6, "gpio_level");
      line_control <= 8'h80;
      host.wr(A_SFR, 8'h03);
      line_control <= 8'h00;
      host.wr(A_SPR, 8'h3C);
      chk("gpio_hi", gpo[15:8], 8'h3C);
      line_control <= 8'h80;
      host.wr(A_SFR, 8'h05);
      line_control <= LCR_ENH_KEY;
      host.wr(A_GPIO_MASK, 8'h01);
      chk("gpio_irq", girq, 1'b0);
      gpi <= 16'h0007;
      @(posedge clk);
      chk("gpio_irq", girq, 1'b1);
      line_control <= 8'h80;
      host.wr(A_SFR, 8'h00);
      line_control <= 8'h00;
      rc(A_SPR, 8'h5A, "scratch");
      $display("test gpio done");
      feature_control <= 8'h40;
      host.wr(A_SPR, 8'h13);
      chk("tx_oe_n", t_oe, 1'b1);
      rc(A_SPR, 8'h11, "count");
      rc(A_SPR, 8'h22, "count");
      rc(A_SPR, 8'h11, "count");
      host.wr(A_SPR, 8'h05);
      chk("tx_oe_n", t_oe, 1'b0);
      rc(A_SPR, 8'h22, "count");
      misc <= 11'h001;
      @(posedge clk);
      chk("tx_immediate", mode.tx_immediate, 1'b1);
      host.wr(A_THR_DLL, 8'h41);
      misc <= 11'h003;
      @(posedge clk);
      misc <= 11'h001;
      @(posedge clk);
      chk("tx_immediate", mode.tx_immediate, 1'b0);
      feature_control <= 8'h00;
      rc(A_SPR, 8'h5A, "scratch");
      $display("test mode select done");
      feature_control <= 8'h08;
      misc <= 11'h004;
      repeat (2) @(posedge clk);
      chk("rts_n", rts, 1'b0);
      misc <= 11'h000;
      repeat (2) @(posedge clk);
      chk("rts_n", rts, 1'b1);
      misc <= 11'h020;
      @(posedge clk);
      chk("line_err_irq", lerr, 1'b1);
      misc <= 11'h010;
      @(posedge clk);
      chk("line_err_irq", lerr, 1'b0);
      misc <= 11'h040;
      @(posedge clk);
      misc <= 11'h080;
      @(posedge clk);
      misc <= 11'h000;
      chk("pause_irq", pirq, 1'b1);
      @(posedge clk);
      chk("pause_irq", pirq, 1'b0);
      feature_unlock <= 8'h90;
      pins(4'h7);
      chk("tx_halt", mode.tx_halt, 1'b1);
      feature_unlock <= 8'h10;
      @(posedge clk);
      chk("tx_halt", mode.tx_halt, 1'b0);
      $display("test pins done");
      conclude();
   end
endmodule // test_ues_regs
